// >>> docdc_top.sv
/*
 * Dual-output clock divider chain: master tick, reference prescaler,
 * main prescaler and divider, synchronous output enables, power-down
 * and configuration load. Assumes control pins are asynchronous and
 * host write strobes and stored settings come from logic on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "docdc_params.svh"

module docdc_top (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Control pins, asynchronous
    input  wire logic                       ref_control_pin,
    input  wire logic                       main_control_pin,
    // Stored settings
    input  wire logic [`DOCDC_DAC_W-1:0]    nvDacWord,
    input  wire logic [`DOCDC_OFFSET_W-1:0] nvOffset,
    input  wire logic [`DOCDC_PRE_W-1:0]    nvRefPrescaler,
    input  wire logic [`DOCDC_PRE_W-1:0]    nvMainPrescaler,
    input  wire logic [`DOCDC_DIV_W-1:0]    nvDivRatio,
    input  wire logic                       nvDividerBypassBit,
    input  wire logic                       nvRefPinShutdownEn,
    input  wire logic                       nvMainPinShutdownEn,
    // Host writes
    input  wire logic                       hostWrite,
    input  wire logic [`DOCDC_DAC_W-1:0]    hostDacWord,
    input  wire logic [`DOCDC_OFFSET_W-1:0] hostOffset,
    input  wire logic [`DOCDC_PRE_W-1:0]    hostRefPrescaler,
    input  wire logic [`DOCDC_PRE_W-1:0]    hostMainPrescaler,
    input  wire logic [`DOCDC_DIV_W-1:0]    hostDivRatio,
    input  wire logic                       hostDividerBypassBit,
    input  wire logic                       hostRefPinShutdownEn,
    input  wire logic                       hostMainPinShutdownEn,
    // Clock outputs with enables
    output logic                            ref_clk_out,
    output logic                            refClkOe,
    output logic                            main_clk_out,
    output logic                            mainClkOe,
    // Status and oscillator trim
    output logic                            oscStopped,
    output logic                            cfgLoaded,
    output logic [`DOCDC_DAC_W-1:0]         oscDacWord,
    output logic [`DOCDC_OFFSET_W-1:0]      oscOffset,
    output logic [`DOCDC_FREQ_W-1:0]        masterFreqHz
);

    // ************************************************************
    // State and helpers
    // ************************************************************
    docdc_pkg::docdc_top_state_type s_q;
    docdc_pkg::docdc_top_state_type s_d;
    logic                           masterTick;
    logic                           refTick;
    logic                           mainPreTick;
    logic                           mainTick;

    // Master frequency from offset and word
    function automatic logic [`DOCDC_FREQ_W-1:0] freqOf(
        input logic [`DOCDC_OFFSET_W-1:0] off,
        input logic [`DOCDC_DAC_W-1:0]    word
    );
        logic [31:0] sum;
        sum = 32'(`DOCDC_RANGE_BASE_HZ)
            + 32'(off) * 32'(`DOCDC_OFFSET_STEP_HZ)
            + 32'(word) * 32'(`DOCDC_STEP_HZ);
        freqOf = sum[`DOCDC_FREQ_W-1:0];
    endfunction

    // ************************************************************
    // Divider chain
    // ************************************************************
    // one master tick
    assign masterTick = !s_q.powerDown;

    docdc_prescaler u_ref_prescaler (
        .clk      (clk),
        .rstn     (rstn),
        .clear    (!s_q.refOe),
        .tickIn   (masterTick),
        .ratioSel (s_q.refPre),
        .tickOut  (refTick)
    );

    docdc_prescaler u_main_prescaler (
        .clk      (clk),
        .rstn     (rstn),
        .clear    (!s_q.mainOe),
        .tickIn   (masterTick),
        .ratioSel (s_q.mainPre),
        .tickOut  (mainPreTick)
    );

    // Main divider after the main prescaler
    docdc_divider u_main_divider (
        .clk       (clk),
        .rstn      (rstn),
        .clear     (!s_q.mainOe),
        .tickIn    (mainPreTick),
        .ratioCode (s_q.divCode),
        .bypass    (s_q.bypass),
        .tickOut   (mainTick)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;

        // Pin synchronisers
        s_d.refPinSync  = {s_q.refPinSync[0], ref_control_pin};
        s_d.mainPinSync = {s_q.mainPinSync[0], main_control_pin};

        if (!s_q.loaded) begin
            s_d.loaded    = 1'b1;
            s_d.dac       = nvDacWord;
            s_d.offset    = nvOffset;
            s_d.refPre    = nvRefPrescaler;
            s_d.mainPre   = nvMainPrescaler;
            s_d.divCode   = nvDivRatio;
            s_d.bypass    = nvDividerBypassBit;
            s_d.refPdnEn  = nvRefPinShutdownEn;
            s_d.mainPdnEn = nvMainPinShutdownEn;
        end else if (hostWrite) begin
            s_d.dac       = hostDacWord;
            s_d.offset    = hostOffset;
            s_d.refPre    = hostRefPrescaler;
            s_d.mainPre   = hostMainPrescaler;
            s_d.divCode   = hostDivRatio;
            s_d.bypass    = hostDividerBypassBit;
            s_d.refPdnEn  = hostRefPinShutdownEn;
            s_d.mainPdnEn = hostMainPinShutdownEn;
        end

        s_d.powerDown = (s_q.refPdnEn && s_q.refPinSync[1])
                      || (s_q.mainPdnEn && s_q.mainPinSync[1]);

        s_d.refOe  = !s_q.refPinSync[1] && !s_d.powerDown;
        s_d.mainOe = !s_q.mainPinSync[1] && !s_d.powerDown;

        if (!s_q.refOe) begin
            s_d.refOut = 1'b0;
        end else if (refTick) begin
            s_d.refOut = !s_q.refOut;
        end
        if (!s_q.mainOe) begin
            s_d.mainOut = 1'b0;
        end else if (mainTick) begin
            s_d.mainOut = !s_q.mainOut;
        end
        if (!s_d.refOe) begin
            s_d.refOut = 1'b0;
        end
        if (!s_d.mainOe) begin
            s_d.mainOut = 1'b0;
        end

        s_d.freqHz = freqOf(s_q.offset, s_q.dac);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{loaded:    1'b0,
                     dac:       `DOCDC_RST_DAC,
                     offset:    `DOCDC_RST_OFFSET,
                     refPre:    `DOCDC_RST_PRE,
                     mainPre:   `DOCDC_RST_PRE,
                     divCode:   `DOCDC_RST_DIV,
                     bypass:    1'b0,
                     refPdnEn:  1'b0,
                     mainPdnEn: 1'b0,
                     refPinSync: 2'h3,
                     mainPinSync: 2'h3,
                     powerDown: 1'b0,
                     refOut:    1'b0,
                     refOe:     1'b0,
                     mainOut:   1'b0,
                     mainOe:    1'b0,
                     freqHz:    '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign ref_clk_out  = s_q.refOut;
    assign refClkOe     = s_q.refOe;
    assign main_clk_out = s_q.mainOut;
    assign mainClkOe    = s_q.mainOe;
    assign oscStopped   = s_q.powerDown;
    assign cfgLoaded    = s_q.loaded;
    assign oscDacWord   = s_q.dac;
    assign oscOffset    = s_q.offset;
    assign masterFreqHz = s_q.freqHz;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_PDN_OR: assert property (@(posedge clk) disable iff (!rstn)
        s_q.loaded ##0 ((s_q.refPdnEn && s_q.refPinSync[1])
                        || (s_q.mainPdnEn && s_q.mainPinSync[1])) |=> oscStopped)
        else $error("pin power-down request not honoured");

    AST_PDN_FLOATS: assert property (@(posedge clk) disable iff (!rstn)
        oscStopped |-> !refClkOe && !mainClkOe && !ref_clk_out && !main_clk_out)
        else $error("output driven during power-down");

    AST_MAIN_PIN_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
        s_q.mainPinSync[1] |=> !mainClkOe)
        else $error("main output driven while its pin is high");

    AST_NV_LOAD: assert property (@(posedge clk) disable iff (!rstn)
        !cfgLoaded |=> cfgLoaded && oscDacWord == $past(nvDacWord)
                       && s_q.divCode == $past(nvDivRatio))
        else $error("stored settings not loaded after reset");

    AST_HOST_WRITE: assert property (@(posedge clk) disable iff (!rstn)
        cfgLoaded && hostWrite |=> oscDacWord == $past(hostDacWord)
                                  && s_q.mainPre == $past(hostMainPrescaler))
        else $error("host write not applied");

    AST_FREQ: assert property (@(posedge clk) disable iff (!rstn)
        cfgLoaded ##1 1'b1 |-> masterFreqHz == freqOf($past(oscOffset), $past(oscDacWord)))
        else $error("master frequency value wrong");

    AST_ENABLE_LOW_START: assert property (@(posedge clk) disable iff (!rstn)
        $rose(mainClkOe) && !(s_q.bypass && s_q.mainPre == `DOCDC_PRE_BY1)
        |-> !main_clk_out ##1 !main_clk_out)
        else $error("main output started with a short pulse");

    AST_REF_FIRST_EDGE: assert property (@(posedge clk) disable iff (!rstn)
        $rose(refClkOe) && s_q.refPre == `DOCDC_PRE_DIV2
        ##1 refClkOe |-> !ref_clk_out ##1 ref_clk_out)
        else $error("reference first edge not at fixed delay");

    AST_MAIN_LOW_START: assert property (@(posedge clk) disable iff (!rstn)
        $rose(mainClkOe) |-> !main_clk_out)
        else $error("main output enabled high");

    AST_REF_LOW_START: assert property (@(posedge clk) disable iff (!rstn)
        $rose(refClkOe) |-> !ref_clk_out)
        else $error("reference output enabled high");

    AST_REF_PIN_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
        s_q.refPinSync[1] |=> !refClkOe)
        else $error("reference output driven while its pin is high");

    AST_PINS_LOW_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.refPinSync[1] && !s_q.mainPinSync[1] |=> refClkOe && mainClkOe)
        else $error("outputs not enabled with both pins low");

    AST_MAIN_PIN_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.mainPinSync[1] && !s_q.mainPdnEn
        && !(s_q.refPdnEn && s_q.refPinSync[1]) |=> mainClkOe)
        else $error("main output not enabled with its pin low");

    AST_REF_OFF_LOW: assert property (@(posedge clk) disable iff (!rstn)
        !refClkOe |-> !ref_clk_out)
        else $error("disabled reference output not low");

    AST_MAIN_OFF_LOW: assert property (@(posedge clk) disable iff (!rstn)
        !mainClkOe |-> !main_clk_out)
        else $error("disabled main output not low");

    AST_NO_PDN_UNARMED: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.refPdnEn && !s_q.mainPdnEn |=> !oscStopped)
        else $error("power-down without an armed pin");

    AST_REF_MOVES_ON_TICK: assert property (@(posedge clk) disable iff (!rstn)
        s_q.refOe && !refTick |=> $stable(ref_clk_out) || !refClkOe)
        else $error("reference output moved without a tick");

    AST_MAIN_MOVES_ON_TICK: assert property (@(posedge clk) disable iff (!rstn)
        s_q.mainOe && !mainTick |=> $stable(main_clk_out) || !mainClkOe)
        else $error("main output moved without a tick");

endmodule
`default_nettype wire

// >>> docdc_params.svh
/*
 * Constants of the dual-output clock divider chain: field widths,
 * reset values, frequency steps and prescaler select codes.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef DOCDC_PARAMS_SVH
`define DOCDC_PARAMS_SVH

// ****************************************************************
// Field widths
// ****************************************************************
`define DOCDC_DAC_W         10
`define DOCDC_OFFSET_W      5
`define DOCDC_DIV_W         10
`define DOCDC_PRE_W         2
`define DOCDC_FREQ_W        27

// ****************************************************************
// Frequency arithmetic, in hertz
// ****************************************************************
`define DOCDC_STEP_HZ       5000
`define DOCDC_OFFSET_STEP_HZ 2560000
`define DOCDC_RANGE_BASE_HZ 30720000

// ****************************************************************
// Prescaler select codes and reset values
// ****************************************************************
`define DOCDC_PRE_BY1       2'h0
`define DOCDC_PRE_DIV2      2'h1
`define DOCDC_PRE_DIV4      2'h2
`define DOCDC_PRE_DIV8      2'h3
`define DOCDC_RST_DAC       10'h000
`define DOCDC_RST_OFFSET    5'h00
`define DOCDC_RST_DIV       10'h000
`define DOCDC_RST_PRE       2'h0

`endif

// >>> docdc_pkg.sv
/*
 * Types of the dual-output clock divider chain: the packed state of
 * each module. Assumes docdc_params.svh is on the include path.
 */
`default_nettype none
`include "docdc_params.svh"

package docdc_pkg;

    // Prescaler state
    typedef struct packed {
        logic [2:0]              cnt;
        logic [`DOCDC_PRE_W-1:0] activeSel;
    } docdc_pre_state_type;

    // Programmable divider state
    typedef struct packed {
        logic [`DOCDC_DIV_W:0]   cnt;
        logic [`DOCDC_DIV_W-1:0] activeCode;
        logic                    activeBypass;
    } docdc_div_state_type;

    // Top-level state
    typedef struct packed {
        logic                       loaded;
        logic [`DOCDC_DAC_W-1:0]    dac;
        logic [`DOCDC_OFFSET_W-1:0] offset;
        logic [`DOCDC_PRE_W-1:0]    refPre;
        logic [`DOCDC_PRE_W-1:0]    mainPre;
        logic [`DOCDC_DIV_W-1:0]    divCode;
        logic                       bypass;
        logic                       refPdnEn;
        logic                       mainPdnEn;
        logic [1:0]                 refPinSync;
        logic [1:0]                 mainPinSync;
        logic                       powerDown;
        logic                       refOut;
        logic                       refOe;
        logic                       mainOut;
        logic                       mainOe;
        logic [`DOCDC_FREQ_W-1:0]   freqHz;
    } docdc_top_state_type;

endpackage
`default_nettype wire

// >>> docdc_prescaler.sv
/*
 * Prescaler dividing a tick stream by 1, 2, 4 or 8.
 * Assumes tickIn comes from logic on clk; a new select is taken
 * only at terminal count or while cleared.
 */
`timescale 1ns/10ps
`default_nettype none
`include "docdc_params.svh"

module docdc_prescaler (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clear,
    input  wire logic                    tickIn,
    input  wire logic [`DOCDC_PRE_W-1:0] ratioSel,
    output logic                         tickOut
);
    docdc_pkg::docdc_pre_state_type s_q;
    docdc_pkg::docdc_pre_state_type s_d;

    // Last count value for a select code
    function automatic logic [2:0] lastCount(input logic [`DOCDC_PRE_W-1:0] sel);
        lastCount = 3'((4'h1 << sel) - 4'h1);
    endfunction

    assign tickOut = tickIn && (s_q.cnt == lastCount(s_q.activeSel));

    // Next state
    always_comb begin
        s_d = s_q;
        if (clear || tickOut) begin
            s_d.cnt       = 3'h0;
            s_d.activeSel = ratioSel;
        end else if (tickIn) begin
            s_d.cnt = 3'(s_q.cnt + 3'h1);
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{cnt: 3'h0, activeSel: `DOCDC_RST_PRE};
        end else begin
            s_q <= s_d;
        end
    end

    AST_PRE_DIV8_SPACING: assert property (@(posedge clk) disable iff (!rstn || clear)
        tickOut && ratioSel == `DOCDC_PRE_DIV8 |=> !tickOut [*7])
        else $error("divide-by-8 prescaler ticked early");

    AST_PRE_SEL_AT_TERM: assert property (@(posedge clk) disable iff (!rstn)
        $changed(s_q.activeSel) |-> $past(tickOut) || $past(clear))
        else $error("prescaler ratio changed away from terminal count");

endmodule
`default_nettype wire

// >>> docdc_divider.sv
/*
 * Programmable divider, ratio code + 2 (2 to 1025), with bypass.
 * Assumes tickIn comes from logic on clk; new ratio and bypass are
 * taken at terminal count or while cleared.
 */
`timescale 1ns/10ps
`default_nettype none
`include "docdc_params.svh"

module docdc_divider (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clear,
    input  wire logic                    tickIn,
    input  wire logic [`DOCDC_DIV_W-1:0] ratioCode,
    input  wire logic                    bypass,
    output logic                         tickOut
);
    docdc_pkg::docdc_div_state_type s_q;
    docdc_pkg::docdc_div_state_type s_d;
    logic                           terminal;

    // Terminal when count reaches ratio - 1
    assign terminal = tickIn && (s_q.cnt == 11'({1'b0, s_q.activeCode} + 11'h1));
    assign tickOut  = s_q.activeBypass ? tickIn : terminal;

    // Next state
    always_comb begin
        s_d = s_q;
        if (clear || tickOut) begin
            s_d.cnt          = '0;
            s_d.activeCode   = ratioCode;
            s_d.activeBypass = bypass;
        end else if (tickIn) begin
            s_d.cnt = 11'(s_q.cnt + 11'h1);
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{cnt: '0, activeCode: `DOCDC_RST_DIV, activeBypass: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    AST_DIV_BYPASS_THROUGH: assert property (@(posedge clk) disable iff (!rstn)
        s_q.activeBypass |-> tickOut == tickIn && s_q.cnt == 11'h000)
        else $error("bypassed divider does not pass ticks through");

    AST_DIV_MIN_TWO: assert property (@(posedge clk) disable iff (!rstn)
        tickOut && !bypass |=> !tickOut)
        else $error("divider ratio below two");

endmodule
`default_nettype wire

// >>> docdc_host_model.sv
/*
 * Host-side model of the divider chain: issues whole-set
 * configuration writes as one-cycle pulses.
 * Assumes the device samples host fields on rising clk edges.
 */
`timescale 1ns/10ps
`default_nettype none
`include "docdc_params.svh"

module docdc_host_model (
    input  wire logic        clk,
    output logic             hostWrite,
    output logic [31:0]      hostCfg
);
    // ************************************************************
    // Idle state
    // ************************************************************
    // Bus idle from time zero
    initial begin
        hostWrite = 1'b0;
        hostCfg   = 32'h0000_0000;
    end

    // ************************************************************
    // Write cycle
    // ************************************************************
    // whole-set write
    task automatic wr(input logic [31:0] cfg);
        @(negedge clk);
        hostWrite = 1'b1;
        hostCfg   = cfg;
        @(negedge clk);
        hostWrite = 1'b0;
        hostCfg   = ~cfg; // Fields no longer valid
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 * Self-checking bench of the divider chain: periods, enable delay,
 * power-down and configuration load against an integer model.
 * Assumes docdc_params.svh on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "docdc_params.svh"

module tb_top;
    logic              clk;
    logic              rstn;
    logic              refPin;
    logic              mainPin;
    logic [31:0]       nvCfg;
    wire logic         hostWrite;
    wire logic [31:0]  hostCfg;
    wire logic         refOut;
    wire logic         refOe;
    wire logic         mainOut;
    wire logic         mainOe;
    wire logic         stopped;
    wire logic         loaded;
    wire logic [9:0]   dacW;
    wire logic [4:0]   offW;
    wire logic [26:0]  freq;
    int                miscompares;
    int                samples_checked;
    int unsigned       rngState;
    int                p;
    int                d0;
    int                d1;
    int                hi;
    int                dvTab[5] = '{0, 1, 0, 1023, 5};
    int                mpTab[5] = '{0, 1, 3, 0, 2};
    int                bpTab[5] = '{0, 0, 1, 0, 0};
    logic [31:0]       c;
    logic              expStop;

    docdc_host_model host (.clk(clk), .hostWrite(hostWrite), .hostCfg(hostCfg));

    docdc_top dut (
        .clk(clk), .rstn(rstn),
        .ref_control_pin(refPin), .main_control_pin(mainPin),
        .nvDacWord(nvCfg[31:22]), .nvOffset(nvCfg[21:17]),
        .nvRefPrescaler(nvCfg[16:15]), .nvMainPrescaler(nvCfg[14:13]),
        .nvDivRatio(nvCfg[12:3]), .nvDividerBypassBit(nvCfg[2]),
        .nvRefPinShutdownEn(nvCfg[1]), .nvMainPinShutdownEn(nvCfg[0]),
        .hostWrite(hostWrite),
        .hostDacWord(hostCfg[31:22]), .hostOffset(hostCfg[21:17]),
        .hostRefPrescaler(hostCfg[16:15]), .hostMainPrescaler(hostCfg[14:13]),
        .hostDivRatio(hostCfg[12:3]), .hostDividerBypassBit(hostCfg[2]),
        .hostRefPinShutdownEn(hostCfg[1]), .hostMainPinShutdownEn(hostCfg[0]),
        .ref_clk_out(refOut), .refClkOe(refOe), .main_clk_out(mainOut),
        .mainClkOe(mainOe), .oscStopped(stopped), .cfgLoaded(loaded),
        .oscDacWord(dacW), .oscOffset(offW), .masterFreqHz(freq)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    // Clock, 100 ns period
    always #50 clk = ~clk;

    function automatic int unsigned rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Model of master frequency in hertz
    function automatic int fexp(input logic [31:0] f);
        return `DOCDC_RANGE_BASE_HZ + int'(f[21:17]) * `DOCDC_OFFSET_STEP_HZ
               + int'(f[31:22]) * `DOCDC_STEP_HZ;
    endfunction

    function automatic logic [31:0] cfgw(input int rp, input int mp, input int dv,
                                         input int bp, input int re, input int me);
        return {10'h1f4, 5'h03, 2'(rp), 2'(mp), 10'(dv), 1'(bp), 1'(re), 1'(me)};
    endfunction

    task automatic bad(input string m);
        miscompares++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Period in cycles between the second and third rising edges after the call
    task automatic period(input bit useMain, output int q);
        int n;
        int rises;
        logic prev;
        logic cur;
        n = 0;
        rises = 0;
        q = 0;
        prev = 1'b1;
        while (rises < 3 && n < 20000) begin
            @(negedge clk);
            cur = useMain ? mainOut : refOut;
            if (cur === 1'b1 && prev === 1'b0) begin
                rises++;
            end
            if (rises == 2) begin
                q++;
            end
            prev = cur;
            n++;
        end
        if (rises < 3) begin
            bad("no output edge");
            complete_run();
        end
    endtask

    // Delay from reference enable to first high, and first high width
    task automatic enDelay(output int d, output int h);
        refPin = 1'b1;
        repeat (6) @(negedge clk);
        samples_checked++;
        if (refOe !== 1'b0 || refOut !== 1'b0) bad("disabled output driven");
        refPin = 1'b0;
        d = 0;
        h = 0;
        while (refOut !== 1'b1 && d < 100) begin
            @(negedge clk);
            d++;
        end
        while (refOut === 1'b1 && h < 100) begin
            @(negedge clk);
            h++;
        end
        if (d >= 100 || h >= 100) begin
            bad("enable timeout");
            complete_run();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        rngState = 59085;
        rstn = 1'b0;
        refPin = 1'b0;
        mainPin = 1'b0;
        nvCfg = rnd();
        repeat (3) @(negedge clk);
        samples_checked++;
        if (refOe !== 1'b0 || mainOe !== 1'b0 || loaded !== 1'b0) bad("reset outputs");
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        samples_checked++;
        if (loaded !== 1'b1 || dacW !== nvCfg[31:22] || offW !== nvCfg[21:17]) bad("load");
        samples_checked++;
        if (freq !== 27'(fexp(nvCfg))) bad("stored frequency");
        // Random writes one idle cycle apart, last one wins
        for (int i = 0; i < 4; i++) begin
            c = rnd();
            host.wr(c);
        end
        repeat (2) @(negedge clk);
        samples_checked++;
        if (dacW !== c[31:22] || freq !== 27'(fexp(c))) bad("host frequency");
        // Reference prescaler codes
        for (int i = 0; i < 4; i++) begin
            host.wr(cfgw(i, 0, 0, 0, 0, 0));
            period(1'b0, p);
            samples_checked++;
            if (p != 2 * (1 << i)) bad("reference period");
        end
        // Main prescaler, divider and bypass table
        for (int i = 0; i < 5; i++) begin
            host.wr(cfgw(0, mpTab[i], dvTab[i], bpTab[i], 0, 0));
            period(1'b1, p);
            d0 = bpTab[i] ? 2 * (1 << mpTab[i]) : 2 * (1 << mpTab[i]) * (dvTab[i] + 2);
            samples_checked++;
            if (p != d0) bad("main period");
        end
        // Enable delay repeatable, longer by prescaler ratio - 1, and first pulse full width
        host.wr(cfgw(0, 0, 0, 0, 0, 0));
        enDelay(d0, hi);
        enDelay(d1, hi);
        samples_checked++;
        if (d0 != d1 || hi != 1) bad("enable delay /1");
        host.wr(cfgw(3, 0, 0, 0, 0, 0));
        enDelay(d1, hi);
        samples_checked++;
        if (d1 - d0 != 7 || hi != 8) bad("enable delay /8");
        host.wr(cfgw(1, 0, 0, 0, 0, 0));
        enDelay(d1, hi);
        samples_checked++;
        if (d1 - d0 != 1 || hi != 2) bad("enable delay /2");
        // Pins against shutdown enables, every combination
        for (int i = 0; i < 16; i++) begin
            host.wr(cfgw(0, 0, 0, 0, i % 2, (i / 2) % 2));
            refPin = 1'((i / 4) % 2);
            mainPin = 1'((i / 8) % 2);
            repeat (5) @(negedge clk);
            expStop = (refPin & 1'(i % 2)) | (mainPin & 1'((i / 2) % 2));
            samples_checked++;
            if (stopped !== expStop) bad("power-down");
            samples_checked++;
            if (refOe !== (!expStop && !refPin) || mainOe !== (!expStop && !mainPin))
                bad("output enable");
        end
        complete_run();
    end
endmodule
`default_nettype wire
